/* logic/hoist_brake_pkg.sv */
package hoist_brake_pkg;
	// ------------------------------------------------------------
	// widths and timing
	// ------------------------------------------------------------
	localparam int  SPEED_W          = 16;   // speed in 0.1 Hz units
	localparam int  CURR_W           = 16;   // current in 0.01 % units
	localparam int  TIME_W           = 10;   // time settings in 0.01 s
	localparam int  CLK_HZ           = 40000000;
	localparam int  TICK_US          = 10000; // one setting step, 10 ms
	localparam int  TICK_CYCLES      = CLK_HZ / 1000000 * TICK_US;
	// ------------------------------------------------------------
	// setting limits
	// ------------------------------------------------------------
	localparam logic [SPEED_W-1:0] APPLY_SPEED_MAX  = 16'h00FA; // 25.0 Hz
	localparam logic [TIME_W-1:0]  APPLY_DELAY_MAX  = 10'h1F4;  // 5.00 s
	localparam logic [TIME_W-1:0]  RELEASE_DLY_MAX  = 10'h1F4;  // 5.00 s
	localparam logic [TIME_W-1:0]  CHECK_TIME_MAX   = 10'h3E8;  // 10.00 s
	// ------------------------------------------------------------
	// apply-condition register
	// ------------------------------------------------------------
	localparam int          COND_W          = 5;
	localparam logic [4:0]  COND_RESET      = 5'h00;
	localparam int          COND_SPEED_BIT  = 0;
	localparam int          COND_RUN_BIT    = 4;
	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_HELD    = 4'b0001,
		ST_RELWAIT = 4'b0010,
		ST_OPEN    = 4'b0100,
		ST_LOCKED  = 4'b1000
	} brake_state_e;
endpackage

/* logic/hoist_tick_timer.sv */
`timescale 1ns/1ps
// counts setting steps while enabled, flags when the limit is reached
module hoist_tick_timer #(
	parameter int TICK_CYCLES = 400000,
	parameter int TIME_W      = 10
) (
	input  wire logic              clk_sys,  // system clock
	input  wire logic              rst_n,    // async reset, low
	input  wire logic              run,      // count while high
	input  wire logic [TIME_W-1:0] limit,    // steps to reach
	output logic                   done      // limit reached
);
	localparam int PW = $clog2(TICK_CYCLES + 1);

	logic [PW-1:0]     preFf;
	logic [TIME_W-1:0] cntFf;
	logic [PW-1:0]     nxt_preFf;
	logic [TIME_W-1:0] nxt_cntFf;

	initial begin
		if (TICK_CYCLES < 1) $error("tick too short");
	end

	assign done = run && (cntFf >= limit);

	// ----------------------------------------------------------
	// prescaler and step counter
	// ----------------------------------------------------------
	always_comb begin
		nxt_preFf = preFf;
		nxt_cntFf = cntFf;
		if (!run) begin
			nxt_preFf = '0;
			nxt_cntFf = '0;
		end else if (!done) begin
			if (preFf == PW'(TICK_CYCLES - 1)) begin
				nxt_preFf = '0;
				nxt_cntFf = cntFf + 1'b1;
			end else begin
				nxt_preFf = preFf + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			preFf <= '0;
			cntFf <= '0;
		end else begin
			preFf <= nxt_preFf;
			cntFf <= nxt_cntFf;
		end
	end
endmodule

/* logic/hoist_pin_sync.sv */
`timescale 1ns/1ps
// three-stage input filter: change accepted when stages two and three agree
module hoist_pin_sync (
	input  wire logic clk_sys,  // system clock
	input  wire logic rst_n,    // async reset, low
	input  wire logic pin,      // raw pin
	output logic      level     // filtered level
);
	logic s1Ff;
	logic s2Ff;
	logic s3Ff;
	logic levelFf;
	logic nxt_levelFf;

	assign level = levelFf;

	// take the new level only once two stages agree
	always_comb begin
		nxt_levelFf = levelFf;
		if (s2Ff == s3Ff) begin
			nxt_levelFf = s3Ff;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1Ff    <= 1'b0;
			s2Ff    <= 1'b0;
			s3Ff    <= 1'b0;
			levelFf <= 1'b0;
		end else begin
			s1Ff    <= pin;
			s2Ff    <= s1Ff;
			s3Ff    <= s2Ff;
			levelFf <= nxt_levelFf;
		end
	end
endmodule

/* logic/hoist_brake_sequencer.sv */
`timescale 1ns/1ps
module hoist_brake_sequencer #(
	parameter int TICK_CYC = hoist_brake_pkg::TICK_CYCLES
) (
	input  wire logic                                clk_sys,        // clock
	input  wire logic                                rst_n,          // reset
	input  wire logic                                runCmd,         // run cmd
	input  wire logic                                outputOn,       // gate on
	input  wire logic                                alarmTrip,      // alarm
	input  wire logic                                coastStop,      // coast
	input  wire logic                                tuningStatic,   // tuning
	input  wire logic                                motor2Sel,      // motor 2
	input  wire logic                                second_motor_function_select, // m2 bit
	input  wire logic [hoist_brake_pkg::SPEED_W-1:0] detSpeed,       // detected
	input  wire logic [hoist_brake_pkg::SPEED_W-1:0] refSpeed,       // reference
	input  wire logic [hoist_brake_pkg::CURR_W-1:0]  outCurrent,     // current
	input  wire logic [hoist_brake_pkg::CURR_W-1:0]  outTorque,      // torque
	input  wire logic [hoist_brake_pkg::CURR_W-1:0]  releaseCurrent, // rel curr
	input  wire logic [hoist_brake_pkg::SPEED_W-1:0] releaseSpeed,   // rel spd
	input  wire logic [hoist_brake_pkg::CURR_W-1:0]  release_torque_level, // trq
	input  wire logic [hoist_brake_pkg::TIME_W-1:0]  release_delay_time, // delay
	input  wire logic [hoist_brake_pkg::SPEED_W-1:0] apply_speed_threshold, // thr
	input  wire logic [hoist_brake_pkg::TIME_W-1:0]  apply_delay_time, // delay
	input  wire logic [hoist_brake_pkg::SPEED_W-1:0] stop_speed_level, // stop
	input  wire logic [hoist_brake_pkg::SPEED_W-1:0] arrival_hysteresis_width, // hy
	input  wire logic [hoist_brake_pkg::TIME_W-1:0]  brake_check_time, // check
	input  wire logic [hoist_brake_pkg::COND_W-1:0]  condWrData,     // cond data
	input  wire logic                                condWrEn,       // cond write
	input  wire logic                                brake_feedback_in, // pin
	output logic [hoist_brake_pkg::COND_W-1:0]       apply_condition_select, // rd
	output logic                                     brake_release_out, // out
	output logic                                     brake_mismatch_alarm // trip
);
	import hoist_brake_pkg::*;

	brake_state_e            stateFf;
	brake_state_e            nxt_stateFf;
	logic [COND_W-1:0]       condFf;
	logic [COND_W-1:0]       nxt_condFf;
	logic                    armedFf;
	logic                    nxt_armedFf;
	logic                    stopSeenFf;
	logic                    nxt_stopSeenFf;
	logic                    aboveFf;
	logic                    nxt_aboveFf;
	logic                    runPrevFf;
	logic                    lockRunOffFf;
	logic                    nxt_lockRunOffFf;
	logic                    mismatchFf;
	logic                    nxt_mismatchFf;
	logic                    fbLevel;
	logic [SPEED_W-1:0]      cmpSpeed;
	logic [SPEED_W-1:0]      applyThr;
	logic [TIME_W-1:0]       applyDly;
	logic [TIME_W-1:0]       relDly;
	logic [TIME_W-1:0]       chkTime;
	logic                    motorOk;
	logic                    forceApply;
	logic                    lowSpeed;
	logic                    applyQual;
	logic                    relCond;
	logic                    applyRun;
	logic                    applyDone;
	logic                    relDone;
	logic                    chkRun;
	logic                    chkDone;

	// clamp a setting to its documented maximum
	function automatic logic [TIME_W-1:0] clampTime(
		input logic [TIME_W-1:0] v,
		input logic [TIME_W-1:0] mx
	);
		return (v > mx) ? mx : v;
	endfunction

	initial begin
		if (TICK_CYC < 1) $error("tick count must be positive");
	end

	// ----------------------------------------------------------
	// setting qualification
	// ----------------------------------------------------------
	assign apply_condition_select = condFf;
	assign cmpSpeed = condFf[COND_SPEED_BIT] ? refSpeed : detSpeed;
	assign applyThr = (apply_speed_threshold > APPLY_SPEED_MAX)
		? APPLY_SPEED_MAX : apply_speed_threshold;
	assign applyDly = clampTime(apply_delay_time, APPLY_DELAY_MAX);
	assign relDly   = clampTime(release_delay_time, RELEASE_DLY_MAX);
	assign chkTime  = clampTime(brake_check_time, CHECK_TIME_MAX);
	assign motorOk  = !motor2Sel || second_motor_function_select;
	// immediate apply sources
	assign forceApply = alarmTrip || coastStop || tuningStatic
		|| mismatchFf || !motorOk;
	assign lowSpeed  = (cmpSpeed < applyThr) && stopSeenFf;
	// bit 4 set: run must be off to apply
	assign applyQual = condFf[COND_RUN_BIT] ? !runCmd : 1'b1;
	assign relCond   = runCmd && outputOn && armedFf
		&& (outCurrent > releaseCurrent) && (cmpSpeed > releaseSpeed)
		&& (outTorque >= release_torque_level);
	assign applyRun  = (stateFf == ST_OPEN) && lowSpeed
		&& applyQual;
	assign chkRun    = outputOn && (fbLevel != brake_release_out);

	// ----------------------------------------------------------
	// timers and feedback filter
	// ----------------------------------------------------------
	hoist_tick_timer #(.TICK_CYCLES(TICK_CYC), .TIME_W(TIME_W)) uApply (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.run     (applyRun),
		.limit   (applyDly),
		.done    (applyDone)
	);

	hoist_tick_timer #(.TICK_CYCLES(TICK_CYC), .TIME_W(TIME_W)) uRelease (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.run     (relCond && (stateFf == ST_RELWAIT)),
		.limit   (relDly),
		.done    (relDone)
	);

	hoist_tick_timer #(.TICK_CYCLES(TICK_CYC), .TIME_W(TIME_W)) uCheck (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.run     (chkRun),
		.limit   (chkTime),
		.done    (chkDone)
	);

	hoist_pin_sync uFb (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pin     (brake_feedback_in),
		.level   (fbLevel)
	);

	// ----------------------------------------------------------
	// stop detection, rearm and mismatch latch
	// ----------------------------------------------------------
	always_comb begin
		nxt_condFf       = condWrEn ? condWrData : condFf;
		nxt_stopSeenFf   = stopSeenFf;
		nxt_aboveFf      = aboveFf;
		nxt_armedFf      = armedFf;
		nxt_mismatchFf   = mismatchFf;
		nxt_lockRunOffFf = lockRunOffFf;
		// arm once above level plus hysteresis, stop when below level
		if ({1'b0, cmpSpeed} > ({1'b0, stop_speed_level}
			+ {1'b0, arrival_hysteresis_width})) begin
			nxt_aboveFf    = 1'b1;
			nxt_stopSeenFf = 1'b0;
		end else if (aboveFf && cmpSpeed < stop_speed_level) begin
			nxt_aboveFf    = 1'b0;
			nxt_stopSeenFf = 1'b1;
		end
		// release allowed again only after run off then on
		if (!runCmd) begin
			nxt_lockRunOffFf = 1'b1;
		end
		if (runCmd && !runPrevFf && lockRunOffFf) begin
			nxt_armedFf      = 1'b1;
			nxt_lockRunOffFf = 1'b0;
		end
		if (stateFf == ST_OPEN && nxt_stateFf != ST_OPEN) begin
			nxt_armedFf      = 1'b0;
			nxt_lockRunOffFf = 1'b0;
		end
		// mismatch trip holds until run is removed; set wins
		if (chkDone) begin
			nxt_mismatchFf = 1'b1;
		end else if (!runCmd) begin
			nxt_mismatchFf = 1'b0;
		end
	end

	// ----------------------------------------------------------
	// brake state machine
	// ----------------------------------------------------------
	always_comb begin
		nxt_stateFf = stateFf;
		unique case (stateFf)
			ST_HELD: begin
				if (!forceApply && armedFf) begin
					nxt_stateFf = ST_RELWAIT;
				end
			end
			ST_RELWAIT: begin
				if (forceApply || !runCmd) begin
					nxt_stateFf = ST_HELD;
				end else if (relDone) begin
					nxt_stateFf = ST_OPEN;
				end
			end
			ST_OPEN: begin
				if (forceApply || !outputOn || applyDone) begin
					nxt_stateFf = ST_LOCKED;
				end
			end
			ST_LOCKED: begin
				if (!runCmd) begin
					nxt_stateFf = ST_HELD;
				end
			end
			default: nxt_stateFf = ST_HELD;
		endcase
	end

	assign brake_release_out    = (stateFf == ST_OPEN);
	assign brake_mismatch_alarm = mismatchFf;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stateFf      <= ST_HELD;
			condFf       <= COND_RESET;
			armedFf      <= 1'b0;
			stopSeenFf   <= 1'b0;
			aboveFf      <= 1'b0;
			runPrevFf    <= 1'b0;
			lockRunOffFf <= 1'b1;
			mismatchFf   <= 1'b0;
		end else begin
			stateFf      <= nxt_stateFf;
			condFf       <= nxt_condFf;
			armedFf      <= nxt_armedFf;
			stopSeenFf   <= nxt_stopSeenFf;
			aboveFf      <= nxt_aboveFf;
			runPrevFf    <= runCmd;
			lockRunOffFf <= nxt_lockRunOffFf;
			mismatchFf   <= nxt_mismatchFf;
		end
	end

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	property p_alarmApply;
		@(posedge clk_sys) disable iff (!rst_n)
		(alarmTrip || coastStop) |=> !brake_release_out;
	endproperty
	a_alarmApply: assert property (p_alarmApply)
		else $error("release held through alarm");

	property p_tuneHeld;
		@(posedge clk_sys) disable iff (!rst_n)
		tuningStatic |=> !brake_release_out;
	endproperty
	a_tuneHeld: assert property (p_tuneHeld)
		else $error("release during tuning");

	property p_outOff;
		@(posedge clk_sys) disable iff (!rst_n)
		(brake_release_out && !outputOn) |=> !brake_release_out;
	endproperty
	a_outOff: assert property (p_outOff)
		else $error("release kept with output off");

	property p_relNeedsRun;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(brake_release_out) |-> $past(relDone) && $past(runCmd);
	endproperty
	a_relNeedsRun: assert property (p_relNeedsRun)
		else $error("release without delay");

	property p_noRelock;
		@(posedge clk_sys) disable iff (!rst_n)
		$fell(brake_release_out) ##1 runCmd [*2] |-> !brake_release_out;
	endproperty
	a_noRelock: assert property (p_noRelock)
		else $error("release again without run cycle");

	property p_mismatch;
		@(posedge clk_sys) disable iff (!rst_n)
		chkDone |=> brake_mismatch_alarm ##1 !brake_release_out;
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("mismatch not tripped");

	property p_motor2;
		@(posedge clk_sys) disable iff (!rst_n)
		(motor2Sel && !second_motor_function_select) |=> !brake_release_out;
	endproperty
	a_motor2: assert property (p_motor2)
		else $error("release for unselected motor");

	property p_applyCond;
		@(posedge clk_sys) disable iff (!rst_n)
		(brake_release_out && runCmd && condFf[COND_RUN_BIT] && outputOn
			&& !forceApply)
		|=> brake_release_out;
	endproperty
	a_applyCond: assert property (p_applyCond)
		else $error("applied while running");

	c_release: cover property (@(posedge clk_sys) $rose(brake_release_out));
	c_apply:   cover property (@(posedge clk_sys) $fell(brake_release_out));
	c_trip:    cover property (@(posedge clk_sys) $rose(brake_mismatch_alarm));
endmodule

/* sim/hoist_brake_actuator.sv */
`timescale 1ns/1ps
// brake actuator: contact follows the release command after a lag
module hoist_brake_actuator (
	input  wire logic       clk_sys, // clock
	input  wire logic       rst_n,   // reset
	input  wire logic       relCmd,  // release command
	input  wire logic [3:0] lag,     // lag in cycles
	input  wire logic       stuck,   // frozen contact
	output logic            contact  // feedback contact
);
	logic [3:0] cnt;
	// contact moves once the command has held for lag cycles
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			contact <= 1'b0;
		end else if (stuck || contact == relCmd) begin
			cnt <= 4'h0;
		end else if (cnt >= lag) begin
			cnt <= 4'h0;
			contact <= relCmd;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

/* sim/hoist_brake_sequencer_tb.sv */
`timescale 1ns/1ps
module hoist_brake_sequencer_tb;
	import hoist_brake_pkg::*;
	localparam int TC = 4;
	logic clk_sys, rst_n, runCmd, outputOn, alarmTrip, coastStop;
	logic tuning, m2Sel, m2Fn, wrEn, fb, relOut, almOut, stuck;
	logic [SPEED_W-1:0] detSpd, refSpd, relSpd, aplThr, stopLvl, hyst;
	logic [CURR_W-1:0] outCur, outTrq, relCur, trqLvl;
	logic [TIME_W-1:0] relDly, aplDly, chkTime;
	logic [COND_W-1:0] wrData, condRd;
	logic [3:0] lag;
	int failures, checks, seed, i, k;
	// ------------------------------------------------------------
	// design and brake model
	// ------------------------------------------------------------
	hoist_brake_sequencer #(.TICK_CYC(TC)) u_hoist_brake_sequencer (
		.clk_sys(clk_sys), .rst_n(rst_n), .runCmd(runCmd),
		.outputOn(outputOn), .alarmTrip(alarmTrip), .coastStop(coastStop),
		.tuningStatic(tuning), .motor2Sel(m2Sel),
		.second_motor_function_select(m2Fn),
		.detSpeed(detSpd), .refSpeed(refSpd), .outCurrent(outCur),
		.outTorque(outTrq), .releaseCurrent(relCur),
		.releaseSpeed(relSpd), .release_torque_level(trqLvl),
		.release_delay_time(relDly), .apply_speed_threshold(aplThr),
		.apply_delay_time(aplDly), .stop_speed_level(stopLvl),
		.arrival_hysteresis_width(hyst), .brake_check_time(chkTime),
		.condWrData(wrData), .condWrEn(wrEn), .brake_feedback_in(fb),
		.apply_condition_select(condRd), .brake_release_out(relOut),
		.brake_mismatch_alarm(almOut));
	hoist_brake_actuator u_hoist_brake_actuator (
		.clk_sys(clk_sys), .rst_n(rst_n), .relCmd(relOut), .lag(lag),
		.stuck(stuck), .contact(fb));
	// clock, 25 ns period
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [COND_W-1:0] condVal(input logic s,
		input logic r);
		condVal = '0;
		condVal[COND_SPEED_BIT] = s;
		condVal[COND_RUN_BIT] = r;
	endfunction
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic print_verdict();
		if (failures == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chkBit(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic chkCond(input logic [COND_W-1:0] e);
		checks++;
		if (condRd !== e) begin
			failures++;
			$display("BAD cond exp %h got %h", e, condRd);
		end
	endtask
	// bounded wait on release (w=0) or alarm (w=1)
	task automatic waitFor(input bit w, input logic v);
		int n;
		for (n = 0; n < 300 && (w ? almOut : relOut) !== v; n++) step();
		chkBit(w ? "alarm" : "release", v, w ? almOut : relOut);
		if ((w ? almOut : relOut) !== v) print_verdict();
	endtask
	task automatic writeCond(input logic [COND_W-1:0] v);
		wrData = v;
		wrEn = 1'b1;
		step();
		wrEn = 1'b0;
		chkCond(v);
	endtask
	// run off then on with speed above release level; release after the delay
	task automatic doRelease();
		lag = 4'($unsigned($random(seed)) % 6);
		relDly = 10'($unsigned($random(seed)) % 3 + 1);
		detSpd = 16'h012C;
		refSpd = 16'h012C;
		runCmd = 1'b0;
		step(2);
		runCmd = 1'b1;
		step(2);
		chkBit("early", 1'b0, relOut);
		waitFor(0, 1'b1);
	endtask
	// run off, chosen speed falls; the other stays between levels
	task automatic doStop(input logic useRef);
		aplDly = 10'($unsigned($random(seed)) % 3 + 1);
		runCmd = 1'b0;
		detSpd = useRef ? 16'h003C : 16'h0000;
		refSpd = useRef ? 16'h0000 : 16'h003C;
		step();
		chkBit("hold", 1'b1, relOut);
		waitFor(0, 1'b0);
		step(10);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'heb59;
		failures = 0;
		checks = 0;
		{runCmd, alarmTrip, coastStop, tuning, m2Sel, m2Fn} = '0;
		{wrEn, stuck, outputOn} = 3'b001;
		wrData = '0;
		lag = 4'h2;
		detSpd = '0;
		refSpd = '0;
		outCur = 16'h03E8;
		outTrq = 16'($random(seed));
		relCur = 16'h0064;
		relSpd = 16'h0014;
		trqLvl = 16'h0000;
		aplThr = 16'h0032;
		stopLvl = 16'h0050;
		hyst = 16'h0005;
		relDly = 10'h001;
		aplDly = 10'h001;
		chkTime = 10'h003;
		rst_n = 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		chkBit("rst rel", 1'b0, relOut);
		chkBit("rst alarm", 1'b0, almOut);
		chkCond(COND_RESET);
		// random register contents, then speed source both ways
		for (i = 0; i < 4; i++) writeCond(5'($random(seed)));
		for (i = 0; i < 2; i++) begin
			writeCond(condVal(i[0], 1'b0));
			doRelease();
			doStop(i[0]);
		end
		// forced apply causes, then no re-release while run held
		for (k = 0; k < 4; k++) begin
			doRelease();
			{alarmTrip, coastStop, tuning} = 3'(k < 3 ? 1 << k : 0);
			outputOn = (k != 3);
			step(2);
			chkBit("forced", 1'b0, relOut);
			{alarmTrip, coastStop, tuning, outputOn} = 4'h1;
			step(30);
			chkBit("relock", 1'b0, relOut);
		end
		// run-off qualification keeps release while run is on
		writeCond(condVal(1'b0, 1'b1));
		doRelease();
		detSpd = '0;
		refSpd = '0;
		step(60);
		chkBit("run qual", 1'b1, relOut);
		doStop(1'b0);
		// default condition applies at low speed even with run on
		writeCond(condVal(1'b0, 1'b0));
		doRelease();
		detSpd = '0;
		refSpd = '0;
		waitFor(0, 1'b0);
		// second motor served only with its function bit
		m2Sel = 1'b1;
		runCmd = 1'b0;
		step(2);
		runCmd = 1'b1;
		detSpd = 16'h012C;
		refSpd = 16'h012C;
		step(60);
		chkBit("m2 off", 1'b0, relOut);
		m2Fn = 1'b1;
		doRelease();
		doStop(1'b0);
		m2Sel = 1'b0;
		// feedback stuck applied: alarm after check time, short and max
		for (k = 0; k < 2; k++) begin
			chkTime = k ? CHECK_TIME_MAX : 10'h003;
			stuck = 1'b1;
			doRelease();
			if (k) begin
				step(int'(chkTime) * TC - 40);
				chkBit("alarm early", 1'b0, almOut);
			end
			waitFor(1, 1'b1);
			step();
			chkBit("trip rel", 1'b0, relOut);
			stuck = 1'b0;
			runCmd = 1'b0;
			step(3);
			chkBit("alarm clr", 1'b0, almOut);
		end
		print_verdict();
	end
endmodule
